// file: src/ddro_pkg.sv
// Purpose: Shared constants and types for the double-rate output register block.
// Assumes: One 100 MHz clock; the cell clock is derived by toggling every enabled cycle.
// Notes: Mode and latch settings are static once reset is released.
// How it works
// - Core data is registered before reaching the pad.
// - Single-rate mode passes only first data input.
// - Single-rate element is register or latch.
// - Double-rate captures both inputs on rising edge.
// - Falling edge moves second value into odd stage.
// - Cell clock steers mux in generic double-rate.
// - Extended cell adds memory mode, same other modes.
// - Memory mode captures and retimes like generic.
// - Shifted write strobe steers mux in memory mode.
// - Two cells combine into complementary output pair.
// - Group strobe block shifts and distributes strobe.
package ddro_pkg;
   // Output modes, one-hot
   typedef enum logic [2:0] {
      DDRO_MODE_SDR = 3'b001,
      DDRO_MODE_GENERIC = 3'b010,
      DDRO_MODE_MEMORY = 3'b100
   } ddro_mode_t;

   // Encoding of the mode selection pins
   localparam logic [1:0] DDRO_CODE_SDR = 2'h0;
   localparam logic [1:0] DDRO_CODE_GENERIC = 2'h1;
   localparam logic [1:0] DDRO_CODE_MEMORY = 2'h2;

   // Number of cells in a pair and strobe shift in clock cycles
   localparam int DDRO_CELLS = 2;
   localparam int DDRO_STROBE_SHIFT_CYC = 1;

   // Reset values
   localparam logic DDRO_RST_BIT = 1'b0;
   localparam ddro_mode_t DDRO_RST_MODE = DDRO_MODE_SDR;
endpackage : ddro_pkg

// file: src/ddro_link_if.sv
// Purpose: Carries static configuration and the distributed strobes to the cell logic.
// Assumes: All signals are on clk.
// Notes: Driven by the config holder and the strobe block, read by the top.
`timescale 1ns/1ps
`default_nettype none
interface ddro_link_if;
   ddro_pkg::ddro_mode_t mode;
   logic latch_sel;
   logic pair_en;
   logic write_strobe_shifted;
   logic read_strobe_shifted;

   modport cfg_src (output mode, output latch_sel, output pair_en);
   modport strobe_src (output write_strobe_shifted, output read_strobe_shifted);
   modport sink (input mode, input latch_sel, input pair_en,
      input write_strobe_shifted, input read_strobe_shifted);
endinterface : ddro_link_if
`default_nettype wire

// file: src/ddro_cfg.sv
// Purpose: Holds the static mode configuration of the output cells.
// Assumes: Configuration pins are steady while reset is high.
// Notes: Settings are sampled only while reset is asserted, so changes later are ignored.
`timescale 1ns/1ps
`default_nettype none
module ddro_cfg (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [1:0] cfg_mode_code,
   input wire logic cfg_latch_sel,
   input wire logic cfg_pair_en,
   ddro_link_if.cfg_src link
);
   ddro_pkg::ddro_mode_t mode_reg, mode_next;
   logic latch_reg, latch_next;
   logic pair_reg, pair_next;

   // Capture during reset only, hold afterwards
   always_comb begin
      mode_next = mode_reg;
      latch_next = latch_reg;
      pair_next = pair_reg;
      if (rst) begin
         if (cfg_mode_code == ddro_pkg::DDRO_CODE_GENERIC) begin
            mode_next = ddro_pkg::DDRO_MODE_GENERIC;
         end else if (cfg_mode_code == ddro_pkg::DDRO_CODE_MEMORY) begin
            mode_next = ddro_pkg::DDRO_MODE_MEMORY;
         end else begin
            mode_next = ddro_pkg::DDRO_MODE_SDR; // Unused code falls back to single rate
         end
         latch_next = cfg_latch_sel;
         pair_next = cfg_pair_en;
      end
   end

   // Reset taken regardless of enable so settings are always captured
   always_ff @(posedge clk) begin
      if (ce || rst) begin
         mode_reg <= mode_next;
         latch_reg <= latch_next;
         pair_reg <= pair_next;
      end
   end

   assign link.mode = mode_reg;
   assign link.latch_sel = latch_reg;
   assign link.pair_en = pair_reg;
endmodule : ddro_cfg
`default_nettype wire

// file: src/ddro_strobe.sv
// Purpose: Group strobe block: synchronises the memory strobe pin and shifts it.
// Assumes: Strobe pin is asynchronous to clk and slow against it.
// Notes: Three-stage synchroniser; a level change counts once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ddro_strobe (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic strobe_pin,
   ddro_link_if.strobe_src link
);
   localparam int SH = ddro_pkg::DDRO_STROBE_SHIFT_CYC;
   logic [2:0] sync_reg, sync_next;
   logic level_reg, level_next;
   logic [SH-1:0] delay_reg, delay_next;
   logic [SH:0] shift_full;

   // Synchroniser, filtered level and phase delay line
   always_comb begin
      sync_next = {sync_reg[1:0], strobe_pin};
      level_next = level_reg;
      if (sync_reg[1] == sync_reg[2]) begin
         level_next = sync_reg[2];
      end
      // New level enters at the top and moves toward index 0, for any shift length
      shift_full = {level_reg, delay_reg};
      delay_next = shift_full[SH:1];
      if (rst) begin
         sync_next = '0;
         level_next = ddro_pkg::DDRO_RST_BIT;
         delay_next = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (ce || rst) begin
         sync_reg <= sync_next;
         level_reg <= level_next;
         delay_reg <= delay_next;
      end
   end

   // One shifted strobe feeds every cell of the group
   assign link.write_strobe_shifted = delay_reg[0];
   assign link.read_strobe_shifted = delay_reg[0];
endmodule : ddro_strobe
`default_nettype wire

// file: src/ddro_top.sv
// Purpose: Output register stage for a pair of I/O cells feeding pad output buffers.
// Assumes: clk is 100 MHz; the cell clock is clk divided by two and driven out.
// Notes: Rising and falling cell-clock edges are the enabled cycles with the phase low and
//        high; all logic stays on one clock edge so timing closes without a negative edge.
`timescale 1ns/1ps
`default_nettype none
module ddro_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [1:0] cfg_mode_code,
   input wire logic cfg_latch_sel,
   input wire logic cfg_pair_en,
   input wire logic strobe_pin,
   input wire logic [ddro_pkg::DDRO_CELLS-1:0] first_data_in,
   input wire logic [ddro_pkg::DDRO_CELLS-1:0] second_data_in,
   input wire logic [ddro_pkg::DDRO_CELLS-1:0] out_en_in,
   output logic [ddro_pkg::DDRO_CELLS-1:0] pad_out,
   output logic [ddro_pkg::DDRO_CELLS-1:0] pad_oe,
   output logic cell_clk,
   output logic write_strobe_seen,
   output logic [2:0] mode_status,
   output logic pair_status
);
   localparam int N = ddro_pkg::DDRO_CELLS;

   ddro_link_if link ();

   ddro_cfg u_cfg (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .cfg_mode_code(cfg_mode_code),
      .cfg_latch_sel(cfg_latch_sel),
      .cfg_pair_en(cfg_pair_en),
      .link(link.cfg_src)
   );

   ddro_strobe u_strobe (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .strobe_pin(strobe_pin),
      .link(link.strobe_src)
   );

   // Cell clock phase: low means the next cycle is a rising edge
   logic phase_reg, phase_next;
   logic rise_evt;
   logic fall_evt;
   logic is_sdr;
   logic is_mem;
   logic mux_sel;

   always_comb begin
      phase_next = ~phase_reg;
      if (rst) begin
         phase_next = ddro_pkg::DDRO_RST_BIT;
      end
   end

   always_ff @(posedge clk) begin
      if (ce || rst) begin
         phase_reg <= phase_next;
      end
   end

   // Edge events and mux select source
   assign rise_evt = ~phase_reg;
   assign fall_evt = phase_reg;
   assign is_sdr = (link.mode == ddro_pkg::DDRO_MODE_SDR);
   assign is_mem = (link.mode == ddro_pkg::DDRO_MODE_MEMORY);
   // Memory mode swaps the select source; generic uses the cell clock itself
   assign mux_sel = is_mem ? link.write_strobe_shifted : phase_reg;

   // Per-cell registers
   logic [N-1:0] even_phase_reg, even_phase_next;
   logic [N-1:0] stage_reg, stage_next;
   logic [N-1:0] odd_phase_reg, odd_phase_next;
   logic [N-1:0] pad_reg, pad_next;
   logic [N-1:0] oe_reg, oe_next;
   logic [N-1:0] src_d0;
   logic [N-1:0] src_d1;
   logic [N-1:0] src_oe;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_cell
         // In pair mode the second cell mirrors the first, inverted
         if (g == 1) begin : g_comp
            assign src_d0[g] = link.pair_en ? ~first_data_in[0] : first_data_in[g];
            assign src_d1[g] = link.pair_en ? ~second_data_in[0] : second_data_in[g];
            assign src_oe[g] = link.pair_en ? out_en_in[0] : out_en_in[g];
         end else begin : g_true
            assign src_d0[g] = first_data_in[g];
            assign src_d1[g] = second_data_in[g];
            assign src_oe[g] = out_en_in[g];
         end

         // Next values for one cell
         always_comb begin
            even_phase_next[g] = even_phase_reg[g];
            stage_next[g] = stage_reg[g];
            odd_phase_next[g] = odd_phase_reg[g];
            pad_next[g] = pad_reg[g];
            oe_next[g] = oe_reg[g];
            if (is_sdr) begin
               if (link.latch_sel) begin
                  // Latch is transparent while the cell clock is high
                  if (fall_evt) begin
                     even_phase_next[g] = src_d0[g];
                  end
               end else if (rise_evt) begin
                  even_phase_next[g] = src_d0[g];
               end
               pad_next[g] = even_phase_next[g];
            end else begin
               if (rise_evt) begin
                  even_phase_next[g] = src_d0[g];
                  stage_next[g] = src_d1[g];
               end
               if (fall_evt) begin
                  odd_phase_next[g] = stage_reg[g];
               end
               // Select high gives even, low gives odd: two items per period
               pad_next[g] = mux_sel ? even_phase_reg[g] : odd_phase_reg[g];
            end
            oe_next[g] = src_oe[g]; // Enable registered alongside data to stay aligned
            if (rst) begin
               even_phase_next[g] = ddro_pkg::DDRO_RST_BIT;
               stage_next[g] = ddro_pkg::DDRO_RST_BIT;
               odd_phase_next[g] = ddro_pkg::DDRO_RST_BIT;
               pad_next[g] = ddro_pkg::DDRO_RST_BIT;
               oe_next[g] = ddro_pkg::DDRO_RST_BIT;
            end
         end

         always_ff @(posedge clk) begin
            if (ce || rst) begin
               even_phase_reg[g] <= even_phase_next[g];
               stage_reg[g] <= stage_next[g];
               odd_phase_reg[g] <= odd_phase_next[g];
               pad_reg[g] <= pad_next[g];
               oe_reg[g] <= oe_next[g];
            end
         end
      end
   endgenerate

   // Status and clock outputs, all from flip-flops
   logic cell_clk_reg, cell_clk_next;
   logic strobe_reg, strobe_next;
   logic [2:0] mode_reg, mode_next;
   logic pair_reg, pair_next;

   always_comb begin
      cell_clk_next = phase_next;
      strobe_next = link.write_strobe_shifted;
      mode_next = link.mode;
      pair_next = link.pair_en;
      if (rst) begin
         cell_clk_next = ddro_pkg::DDRO_RST_BIT;
         strobe_next = ddro_pkg::DDRO_RST_BIT;
         mode_next = ddro_pkg::DDRO_RST_MODE;
         pair_next = ddro_pkg::DDRO_RST_BIT;
      end
   end

   always_ff @(posedge clk) begin
      if (ce || rst) begin
         cell_clk_reg <= cell_clk_next;
         strobe_reg <= strobe_next;
         mode_reg <= mode_next;
         pair_reg <= pair_next;
      end
   end

   assign pad_out = pad_reg;
   assign pad_oe = oe_reg;
   assign cell_clk = cell_clk_reg;
   assign write_strobe_seen = strobe_reg;
   assign mode_status = mode_reg;
   assign pair_status = pair_reg;
endmodule : ddro_top
`default_nettype wire

// file: verif/ddro_pad_model.sv
// Purpose: Far-side model: the memory strobe source seen by the cell group.
// Assumes: The strobe runs only inside a burst and rests at a set level outside.
// Notes: Own ns timing, unrelated in phase to clk, so the synchroniser is exercised.
`timescale 1ns/1ps
`default_nettype none
module ddro_pad_model (
   input wire logic burst,
   input wire logic idle_lvl,
   output logic strobe_pin
);
   // Toggle within a burst; park at the idle level between bursts
   initial begin
      strobe_pin = 1'b0;
      forever begin
         #27;
         strobe_pin = burst ? ~strobe_pin : idle_lvl;
      end
   end
endmodule : ddro_pad_model
`default_nettype wire

// file: verif/ddro_top_sva.sv
// Purpose: Port-level checker of the output register stage.
// Assumes: One clock; checks other than reset, toggle and freeze wait three enabled cycles after reset for the pipe to fill.
// Notes: Latch choice is captured here the same way the cell captures it.
`timescale 1ns/1ps
`default_nettype none
module ddro_top_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic cfg_latch_sel,
   input wire logic strobe_pin,
   input wire logic [ddro_pkg::DDRO_CELLS-1:0] first_data_in,
   input wire logic [ddro_pkg::DDRO_CELLS-1:0] second_data_in,
   input wire logic [ddro_pkg::DDRO_CELLS-1:0] out_en_in,
   input wire logic [ddro_pkg::DDRO_CELLS-1:0] pad_out,
   input wire logic [ddro_pkg::DDRO_CELLS-1:0] pad_oe,
   input wire logic cell_clk,
   input wire logic write_strobe_seen,
   input wire logic [2:0] mode_status,
   input wire logic pair_status
);
   logic [1:0] age_reg, age_next;
   logic latch_reg, latch_next;
   logic settled;
   // Enabled edges since reset, saturating at 3: status and pipe only move with enable
   // Latch choice only follows the pin in reset
   always_comb begin
      age_next = rst ? 2'h0 : age_reg + {1'b0, ce && age_reg != 2'h3};
      latch_next = rst ? cfg_latch_sel : latch_reg;
      settled = age_reg == 2'h3;
   end
   always_ff @(posedge clk) begin
      age_reg <= age_next;
      latch_reg <= latch_next;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_reset_clear: assert property ($fell(rst) |->
      pad_out == 2'h0 && pad_oe == 2'h0 && !cell_clk && mode_status == 3'h1)
      else $error("outputs not cleared by reset");
   chk_cclk_toggle: assert property (ce |=> cell_clk != $past(cell_clk))
      else $error("cell clock did not toggle");
   chk_freeze_all: assert property (!ce |=> $stable(pad_out) && $stable(pad_oe)
      && $stable(cell_clk)) else $error("state moved with enable low");
   chk_oe_follow: assert property (ce && !pair_status && settled |=>
      pad_oe == $past(out_en_in)) else $error("pad enable wrong");
   chk_pair_oe: assert property (ce && pair_status && settled |=>
      pad_oe == {2{$past(out_en_in[0])}}) else $error("paired enable wrong");
   chk_sdr_take: assert property (mode_status == 3'h1 && settled && ce &&
      cell_clk == latch_reg |=> pad_out[0] == $past(first_data_in[0]))
      else $error("single rate capture wrong");
   chk_sdr_hold: assert property (mode_status == 3'h1 && settled && ce &&
      cell_clk != latch_reg |=> $stable(pad_out)) else $error("single rate output moved");
   chk_gen_even: assert property (mode_status == 3'h2 && settled && ce &&
      $past(ce) && cell_clk |=> pad_out[0] == $past(first_data_in[0], 2))
      else $error("even item wrong");
   chk_gen_odd: assert property (mode_status == 3'h2 && settled && ce &&
      $past(ce) && $past(ce, 2) && !cell_clk |=> pad_out[0] == $past(second_data_in[0], 3))
      else $error("odd item wrong");
   chk_mode_static: assert property (settled |-> $onehot(mode_status) &&
      $stable(mode_status) && $stable(pair_status)) else $error("mode status moved");
   chk_strobe_high: assert property ((settled && ce && strobe_pin)[*8] |->
      write_strobe_seen) else $error("strobe not seen");
endmodule : ddro_top_sva
bind ddro_top ddro_top_sva CHK (.clk, .rst, .ce, .cfg_latch_sel, .strobe_pin, .first_data_in,
   .second_data_in, .out_en_in, .pad_out, .pad_oe, .cell_clk, .write_strobe_seen,
   .mode_status, .pair_status);
`default_nettype wire

// file: verif/ddro_top_tb.sv
// Purpose: Random self-checking bench for the output register stage.
// Assumes: Inputs change at the falling edge; config pins scramble after reset.
// Notes: Memory-mode output is only judged with the strobe parked.
`timescale 1ns/1ps
`default_nettype none
module ddro_top_tb;
   logic clk, rst, ce, latch_sel, pair_en, burst, idle_lvl, strobe_pin, cell_clk;
   logic strobe_seen, pair_status, ph, m_vld, m_latch, m_pair;
   logic [1:0] mode_code, d0, d1, oe_in, pad_out, pad_oe, m_code, ev, st, od, pd, m_oe;
   logic [2:0] mode_status;
   logic [31:0] seed;
   int num_errors = 0, checks_done = 0, age;
   ddro_top DUT (.clk(clk), .rst(rst), .ce(ce), .cfg_mode_code(mode_code),
      .cfg_latch_sel(latch_sel), .cfg_pair_en(pair_en), .strobe_pin(strobe_pin),
      .first_data_in(d0), .second_data_in(d1), .out_en_in(oe_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .cell_clk(cell_clk), .write_strobe_seen(strobe_seen),
      .mode_status(mode_status), .pair_status(pair_status));
   ddro_pad_model PEER (.burst(burst), .idle_lvl(idle_lvl), .strobe_pin(strobe_pin));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [2:0] exp_mode(input logic [1:0] c);
      return c == 2'h1 ? 3'h2 : (c == 2'h2 ? 3'h4 : 3'h1);
   endfunction : exp_mode
   // Reference cell; a pair feeds cell one from cell zero and inverts at the pad
   always @(posedge clk) begin
      if (rst) begin
         {ph, m_vld, ev, st, od, pd, m_oe} <= '0;
         {m_code, m_latch, m_pair} <= {mode_code, latch_sel, pair_en};
         age <= 0;
      end else begin
         if (ce) begin
            age <= age + 1; // Count enabled edges, as status only moves on them
            ph <= ~ph;
            m_oe <= m_pair ? {2{oe_in[0]}} : oe_in;
            if (!ph) begin
               ev <= m_pair ? {2{d0[0]}} : d0;
               st <= m_pair ? {2{d1[0]}} : d1;
            end else begin
               od <= st;
            end
            if (m_code[0] ~^ m_code[1]) begin
               if (ph == m_latch) begin
                  pd <= m_pair ? {2{d0[0]}} : d0;
                  m_vld <= 1'b1;
               end
            end else begin
               pd <= ph ? ev : od;
               m_vld <= m_vld | ph; // Reset contents are not inverted, so wait for real data
            end
         end
      end
   end
   task automatic check(input logic [2:0] seen, input logic [2:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic run(input logic [1:0] code, input logic lat, input logic pr, input int n);
      @(negedge clk);
      {rst, mode_code, latch_sel, pair_en} = {1'b1, code, lat, pr};
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (n) begin
         @(negedge clk);
         check({2'h0, cell_clk}, {2'h0, ph});
         check({1'b0, pad_oe}, {1'b0, m_oe});
         if (m_vld && m_code != 2'h2) check({1'b0, pad_out}, {1'b0, pd ^ {m_pair, 1'b0}});
         if (age > 1) check(mode_status, exp_mode(m_code));
         if (age > 1) check({2'h0, pair_status}, {2'h0, m_pair});
         seed = lfsr(seed);
         {ce, d0, d1, oe_in, mode_code, latch_sel, pair_en, burst} = {|seed[2:0], seed[13:3]};
      end
   endtask : run
   task automatic report_and_stop;
      if (num_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   // Clock at 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Every mode, element and pairing choice, then memory mode with a parked strobe
   initial begin
      {rst, ce, d0, d1, oe_in, mode_code, latch_sel, pair_en, burst, idle_lvl} = 14'h2000;
      seed = 32'h5182C9B1;
      for (int i = 0; i < 16; i++) run(i[3:2], i[1], i[0], 60);
      run(2'h2, 1'b0, 1'b0, 0);
      {ce, burst, d0, d1} = {2'b10, 2'h2, 2'h1};
      for (int k = 1; k >= 0; k--) begin
         idle_lvl = k[0];
         repeat (12) @(negedge clk);
         check({2'h0, strobe_seen}, {2'h0, k[0]});
         check({1'b0, pad_out}, {1'b0, k[0] ? 2'h2 : 2'h1});
      end
      report_and_stop();
   end
   // Watchdog well beyond the expected run of about 1050 cycles
   initial begin
      #50000;
      num_errors++;
      report_and_stop();
   end
endmodule : ddro_top_tb
`default_nettype wire
